// *** hw/odc_update_ctrl.sv ***
// Update, clear, reset and power-down control of the octal converter
// Behaviour
// - Clear grounds outputs, buffers high impedance
// - Load pulses ignored during clear
// - Clear release with load high stays cleared
// - Clear release with load low restores latches
// - Clear leaves all data registers untouched
// - Power-on loads strap-chosen values, input zeroed
// - Dual supply resets data and offset codes
// - Single supply: offset off, data per straps
// - Hardware reset applies defaults, blocks interface
// - After reset, values stay, interface resumes
// - Update mode latched at power-on from load
// - Reload only written channels or load request
// - Async ignores load; engine off updates on select
// - Async with engine updates each channel individually
// - Sync load updates written latches, after engine; a load that meets an engine write is dropped
// - Sync without load keeps latches unchanged
// - Monitor register enables and selects source
// - Disabled monitor pin is high impedance
// - Group sleep grounds that group's outputs
// - Interface stays active; wake within 200us
// - Gain change resets offset to new default
`timescale 1ns/1ps
`default_nettype none
module odc_update_ctrl
  import odc_pkg::*;
#(
  parameter int unsigned WAKE_CYCLES = WAKE_CYC
) (
  // Clock and power-on reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // Pins
  input wire logic i_output_clear_n,
  input wire logic i_hw_reset_n,
  input wire logic i_latch_load_n,
  input wire logic i_reset_level_strap,
  input wire logic i_code_format_strap,
  input wire logic i_single_supply,
  // Register writes decoded from the serial interface
  input wire logic i_select_n,
  input wire odc_write_t i_write,
  input wire logic i_load_request_bit,
  input wire logic i_correction_engine_enable,
  input wire odc_write_t i_engine_write,
  input wire logic [1:0] i_gain6,
  input wire logic [1:0] i_group_sleep_bit,
  input wire odc_monitor_t i_monitor,
  // Outputs
  output logic o_serial_enable,
  output logic o_sdo_hold_z,
  output logic [127:0] o_channel_output,
  output logic [7:0] o_channel_drive,
  output logic [7:0] o_channel_pulldown,
  output logic [15:0] o_input_data,
  output logic [31:0] o_offset_code,
  output logic [1:0] o_offset_enable,
  output logic o_monitor_pin_oe,
  output logic [3:0] o_monitor_source,
  output logic [1:0] o_group_ready
);
  localparam int unsigned CW = $clog2(WAKE_CYCLES + 1);

  // Zero recovery would leave the sleep countdown without a width
  if (WAKE_CYCLES < 1) begin : g_bad_wake
    $error("WAKE_CYCLES must be at least one");
  end

  typedef struct packed {
    odc_mode_t mode;
    logic sync_mode;
    logic [1:0] boot;
    logic [1:0] clr_s;
    logic [1:0] rst_s;
    logic [1:0] ld_s;
    logic ld_prev;
    logic sel_prev;
    logic cleared;
    logic [7:0] dirty;
    logic [127:0] data;
    logic [127:0] latch;
    logic [15:0] in_data;
    logic [31:0] offset;
    logic [1:0] gain_prev;
    logic [1:0][CW-1:0] wake;
    logic mon_oe;
    logic [3:0] mon_src;
  } odc_state_t;

  logic [1:0] rst_pipe_ff;
  logic rst_n_int;
  odc_state_t st_ff;
  odc_state_t nxt_st;

  // Reset release through two flip-flops
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rst_pipe_ff <= 2'b00;
    end else begin
      rst_pipe_ff <= {rst_pipe_ff[0], 1'b1};
    end
  end
  assign rst_n_int = rst_pipe_ff[1];

  function automatic logic [15:0] reset_code(input logic lvl, input logic fmt);
    reset_code = (lvl ^ fmt) ? DATA_RST_MID : DATA_RST_ZERO;
  endfunction

  function automatic logic [15:0] offset_code(input logic single, input logic fmt,
                                              input logic g6);
    if (single) begin
      offset_code = OFS_OFF;
    end else if (g6) begin
      offset_code = fmt ? OFS_G6_TWC : OFS_G6_BIN;
    end else begin
      offset_code = fmt ? OFS_G4_TWC : OFS_G4_BIN;
    end
  endfunction

  logic clr_n_s;
  logic hrst_n_s;
  logic ld_n_s;
  logic ld_fall;
  logic sel_rise;
  logic load_evt;
  assign clr_n_s = st_ff.clr_s[1];
  assign hrst_n_s = st_ff.rst_s[1];
  assign ld_n_s = st_ff.ld_s[1];
  assign ld_fall = st_ff.ld_prev && !ld_n_s;
  assign sel_rise = !st_ff.sel_prev && i_select_n;
  // Load pulses during clear do not count
  assign load_evt = st_ff.sync_mode && clr_n_s && (ld_fall || i_load_request_bit);

  always_comb begin
    logic [15:0] rc;
    rc = reset_code(i_reset_level_strap, i_code_format_strap);
    nxt_st = st_ff;
    nxt_st.clr_s = {st_ff.clr_s[0], i_output_clear_n};
    nxt_st.rst_s = {st_ff.rst_s[0], i_hw_reset_n};
    nxt_st.ld_s = {st_ff.ld_s[0], i_latch_load_n};
    nxt_st.ld_prev = ld_n_s;
    nxt_st.sel_prev = i_select_n;
    case (st_ff.mode)
      ODC_BOOT: begin
        // Load level is read only once its synchroniser holds the pin, not its reset value
        nxt_st.boot = st_ff.boot + 2'h1;
        if (st_ff.boot == 2'h2) begin
          nxt_st.sync_mode = ld_n_s;
          nxt_st.mode = ODC_RUN;
        end
        nxt_st.data = {8{rc}};
        nxt_st.latch = {8{rc}};
        nxt_st.in_data = IN_DATA_RST;
        nxt_st.offset = {offset_code(i_single_supply, i_code_format_strap, i_gain6[1]),
                         offset_code(i_single_supply, i_code_format_strap, i_gain6[0])};
        nxt_st.gain_prev = i_gain6;
        nxt_st.dirty = 8'h00;
        nxt_st.cleared = !clr_n_s;
      end
      ODC_HWRST: begin
        nxt_st.data = {8{rc}};
        nxt_st.latch = {8{rc}};
        nxt_st.in_data = IN_DATA_RST;
        nxt_st.offset = {offset_code(i_single_supply, i_code_format_strap, i_gain6[1]),
                         offset_code(i_single_supply, i_code_format_strap, i_gain6[0])};
        nxt_st.gain_prev = i_gain6;
        nxt_st.dirty = 8'h00;
        if (hrst_n_s) begin
          nxt_st.mode = ODC_RUN;
        end
      end
      ODC_RUN: begin
        if (!hrst_n_s) begin
          nxt_st.mode = ODC_HWRST;
        end else begin
          // Writes land on select rise; clear never touches registers
          if (sel_rise && i_write.valid) begin
            nxt_st.in_data = i_write.data;
            if (!i_correction_engine_enable) begin
              nxt_st.data[i_write.chan*16 +: 16] = i_write.data;
              nxt_st.dirty[i_write.chan] = 1'b1;
              if (!st_ff.sync_mode) begin
                nxt_st.latch[i_write.chan*16 +: 16] = i_write.data;
              end
            end
          end
          if (i_engine_write.valid && i_correction_engine_enable) begin
            nxt_st.data[i_engine_write.chan*16 +: 16] = i_engine_write.data;
            nxt_st.dirty[i_engine_write.chan] = 1'b1;
            if (!st_ff.sync_mode) begin
              nxt_st.latch[i_engine_write.chan*16 +: 16] = i_engine_write.data;
            end
          end
          // Engine write drops the simultaneous load; written channels wait for the next load
          if (load_evt && !(i_correction_engine_enable && i_engine_write.valid)) begin
            for (int c = 0; c < 8; c++) begin
              if (st_ff.dirty[c] || i_load_request_bit) begin
                nxt_st.latch[c*16 +: 16] = st_ff.data[c*16 +: 16];
              end
            end
            nxt_st.dirty = 8'h00;
          end
          for (int g = 0; g < 2; g++) begin
            if (i_gain6[g] != st_ff.gain_prev[g]) begin
              nxt_st.offset[g*16 +: 16] =
                offset_code(i_single_supply, i_code_format_strap, i_gain6[g]);
            end
          end
          nxt_st.gain_prev = i_gain6;
        end
      end
      default: nxt_st.mode = ODC_BOOT;
    endcase
    // Clear holds until load low, so a held high load keeps outputs at ground
    if (!clr_n_s) begin
      nxt_st.cleared = 1'b1;
    end else if (!ld_n_s) begin
      nxt_st.cleared = 1'b0;
    end
    for (int g = 0; g < 2; g++) begin
      if (i_group_sleep_bit[g]) begin
        nxt_st.wake[g] = CW'(WAKE_CYCLES);
      end else if (st_ff.wake[g] != '0) begin
        nxt_st.wake[g] = st_ff.wake[g] - CW'(1);
      end
    end
    nxt_st.mon_oe = i_monitor.enable;
    nxt_st.mon_src = i_monitor.source;
  end

  always_ff @(posedge i_clk or negedge rst_n_int) begin
    if (!rst_n_int) begin
      st_ff <= '0;
      st_ff.mode <= ODC_BOOT;
      st_ff.clr_s <= 2'b11;
      st_ff.rst_s <= 2'b11;
      st_ff.ld_s <= 2'b11;
      st_ff.ld_prev <= 1'b1;
      st_ff.sel_prev <= 1'b1;
      st_ff.cleared <= 1'b1;
    end else begin
      st_ff <= nxt_st;
    end
  end

  logic [7:0] grp_off;
  always_comb begin
    for (int c = 0; c < 8; c++) begin
      grp_off[c] = i_group_sleep_bit[c / 4] || (st_ff.wake[c / 4] != '0);
    end
  end

  // Interface stays alive in power-down, blocked by hardware reset and during power-on boot
  assign o_serial_enable = (st_ff.mode == ODC_RUN);
  assign o_sdo_hold_z = (st_ff.mode != ODC_RUN);
  assign o_channel_output = st_ff.latch;
  assign o_channel_drive = ~grp_off & {8{!st_ff.cleared}};
  assign o_channel_pulldown = grp_off | {8{st_ff.cleared}};
  assign o_input_data = st_ff.in_data;
  assign o_offset_code = st_ff.offset;
  assign o_offset_enable = i_single_supply ? 2'b00 : 2'b11;
  assign o_monitor_pin_oe = st_ff.mon_oe;
  assign o_monitor_source = st_ff.mon_src;
  assign o_group_ready = {st_ff.wake[1] == '0 && !i_group_sleep_bit[1],
                          st_ff.wake[0] == '0 && !i_group_sleep_bit[0]};

  a_clear_drive: assert property (@(posedge i_clk) disable iff (!rst_n_int)
    !clr_n_s |=> (o_channel_drive == 8'h00))
    else $error("outputs driven during clear");
  a_clear_load_ignored: assert property (@(posedge i_clk) disable iff (!rst_n_int)
    (!clr_n_s && st_ff.mode == ODC_RUN) |=> $stable(st_ff.latch) || $past(sel_rise))
    else $error("latch moved by load during clear");
  a_clear_stays: assert property (@(posedge i_clk) disable iff (!rst_n_int)
    (st_ff.mode != ODC_BOOT && st_ff.cleared && clr_n_s && ld_n_s) |=> st_ff.cleared)
    else $error("clear released without load low");
  a_clear_restore: assert property (@(posedge i_clk) disable iff (!rst_n_int)
    (clr_n_s && !ld_n_s) |=> !st_ff.cleared)
    else $error("clear not released with load low");
  sequence s_hw_reset;
    st_ff.mode == ODC_HWRST ##1 st_ff.mode == ODC_HWRST;
  endsequence
  a_hwrst_values: assert property (@(posedge i_clk) disable iff (!rst_n_int)
    s_hw_reset |-> (o_input_data == IN_DATA_RST) && !o_serial_enable && o_sdo_hold_z)
    else $error("hardware reset values wrong");
  a_sync_hold: assert property (@(posedge i_clk) disable iff (!rst_n_int)
    (st_ff.mode == ODC_RUN && st_ff.sync_mode && ld_n_s && st_ff.ld_prev
     && !i_load_request_bit && hrst_n_s) |=> $stable(st_ff.latch))
    else $error("sync latch moved without load");
  a_async_select: assert property (@(posedge i_clk) disable iff (!rst_n_int)
    (st_ff.mode == ODC_RUN && hrst_n_s && !st_ff.sync_mode && sel_rise && i_write.valid
     && !i_correction_engine_enable && !i_engine_write.valid)
    |=> st_ff.latch[$past(i_write.chan)*16 +: 16] == $past(i_write.data))
    else $error("async latch not updated on select");
  a_sleep_pull: assert property (@(posedge i_clk) disable iff (!rst_n_int)
    i_group_sleep_bit[0] |-> o_channel_pulldown[3:0] == 4'hF && o_channel_drive[3:0] == 4'h0)
    else $error("sleeping group still driven");
  a_monitor_z: assert property (@(posedge i_clk) disable iff (!rst_n_int)
    !i_monitor.enable |=> !o_monitor_pin_oe)
    else $error("monitor pin driven while disabled");
  a_monitor_select: assert property (@(posedge i_clk) disable iff (!rst_n_int)
    i_monitor.enable |=> o_monitor_pin_oe && (o_monitor_source == $past(i_monitor.source)))
    else $error("monitor source not followed");
  a_boot_mode: assert property (@(posedge i_clk) disable iff (!rst_n_int)
    (st_ff.mode == ODC_BOOT && st_ff.boot == 2'h2) |=> st_ff.sync_mode == $past(ld_n_s))
    else $error("update mode not taken from load level");
  a_engine_async: assert property (@(posedge i_clk) disable iff (!rst_n_int)
    (st_ff.mode == ODC_RUN && hrst_n_s && !st_ff.sync_mode && i_correction_engine_enable
     && i_engine_write.valid)
    |=> st_ff.latch[$past(i_engine_write.chan)*16 +: 16] == $past(i_engine_write.data))
    else $error("engine write did not reach latch");
  // Synchronous load of a written channel, engine idle
  sequence s_sync_load;
    st_ff.mode == ODC_RUN && hrst_n_s && st_ff.sync_mode && clr_n_s && ld_fall
    && !i_correction_engine_enable && st_ff.dirty[0];
  endsequence
  a_sync_load: assert property (@(posedge i_clk) disable iff (!rst_n_int)
    s_sync_load |=> st_ff.latch[15:0] == $past(st_ff.data[15:0]))
    else $error("sync load missed a written channel");
  a_hwrst_latch: assert property (@(posedge i_clk) disable iff (!rst_n_int)
    s_hw_reset |-> o_channel_output == {8{reset_code(i_reset_level_strap, i_code_format_strap)}})
    else $error("hardware reset latch values wrong");
  a_gain_offset: assert property (@(posedge i_clk) disable iff (!rst_n_int)
    (st_ff.mode == ODC_RUN && hrst_n_s && i_gain6[1] != st_ff.gain_prev[1])
    |=> o_offset_code[31:16] == offset_code($past(i_single_supply), $past(i_code_format_strap),
                                            $past(i_gain6[1])))
    else $error("offset not reset on gain change");
  // Recovery counter must run down one per cycle once sleep is cleared
  a_wake_count: assert property (@(posedge i_clk) disable iff (!rst_n_int)
    (!i_group_sleep_bit[0] && st_ff.wake[0] != '0)
    |=> st_ff.wake[0] == $past(st_ff.wake[0]) - CW'(1))
    else $error("wake countdown stalled");
  a_wake_bound: assert property (@(posedge i_clk) disable iff (!rst_n_int)
    st_ff.wake[0] <= CW'(WAKE_CYCLES))
    else $error("wake countdown beyond recovery time");
endmodule
`default_nettype wire

// *** hw/odc_pkg.sv ***
// Shared constants and carrier types for the octal converter control block
package odc_pkg;
  localparam int unsigned CLK_HZ = 100_000_000;
  localparam int unsigned WAKE_US = 200;
  // Longest recovery time rounds down
  localparam int unsigned WAKE_CYC = (WAKE_US * (CLK_HZ / 1_000_000));
  localparam logic [15:0] DATA_RST_ZERO = 16'h0000;
  localparam logic [15:0] DATA_RST_MID = 16'h8000;
  localparam logic [15:0] OFS_G6_BIN = 16'h999A;
  localparam logic [15:0] OFS_G6_TWC = 16'h199A;
  localparam logic [15:0] OFS_G4_BIN = 16'hAAAB;
  localparam logic [15:0] OFS_G4_TWC = 16'h2AAB;
  localparam logic [15:0] OFS_OFF = 16'h0000;
  localparam logic [15:0] IN_DATA_RST = 16'h0000;
  localparam logic [3:0] MON_SRC_AUX0 = 4'h8;
  localparam logic [3:0] MON_SRC_AUX1 = 4'h9;
  localparam logic [3:0] MON_SRC_OFS_A = 4'hA;
  localparam logic [3:0] MON_SRC_OFS_B = 4'hB;
  localparam logic [3:0] MON_SRC_REF_A = 4'hC;
  localparam logic [3:0] MON_SRC_REF_B = 4'hD;

  typedef enum logic [2:0] {
    ODC_BOOT = 3'b001,
    ODC_RUN = 3'b010,
    ODC_HWRST = 3'b100
  } odc_mode_t;

  typedef struct packed {
    logic valid;
    logic [2:0] chan;
    logic [15:0] data;
  } odc_write_t;

  typedef struct packed {
    logic enable;
    logic [3:0] source;
  } odc_monitor_t;
endpackage

// *** tb/odc_host_model.sv ***
// Host controller model: select frames, decoded writes and load pin
`timescale 1ns/1ps
`default_nettype none
module odc_host_model
  import odc_pkg::*;
(
  // Clock and commands
  input wire logic i_clk,
  input wire logic i_hw_reset_n,
  input wire logic i_go,
  input wire logic [2:0] i_chan,
  input wire logic [15:0] i_data,
  input wire logic i_load,
  // Device side
  output logic o_select_n,
  output var odc_write_t o_write,
  output logic o_latch_load_n,
  output logic o_busy
);
  logic [3:0] cnt_ff;
  logic ld_ff;
  initial begin
    cnt_ff = 4'h0;
    ld_ff = 1'b0;
    o_select_n = 1'b1;
    o_latch_load_n = 1'b1;
    o_write = '0;
  end
  always @(posedge i_clk) begin
    if (cnt_ff == 4'h0) begin
      // No frame while the device is held in reset
      if (i_go && i_hw_reset_n) begin
        o_select_n <= 1'b0;
        o_write <= {1'b1, i_chan, i_data};
        ld_ff <= i_load;
        cnt_ff <= 4'h1;
      end
    end else begin
      cnt_ff <= cnt_ff + 4'h1;
      if (cnt_ff == 4'h4) o_select_n <= 1'b1;
      // Released frame data no longer shows the last value
      if (cnt_ff == 4'h5) o_write <= {1'b0, ~o_write.chan, ~o_write.data};
      // Gap after select rise before load
      if (cnt_ff == 4'h7) o_latch_load_n <= ~ld_ff;
      if (cnt_ff == 4'hB) o_latch_load_n <= 1'b1;
    end
  end
  assign o_busy = (cnt_ff != 4'h0);
endmodule
`default_nettype wire

// *** tb/odc_update_ctrl_bench.sv ***
// Self-checking bench of the octal converter update control
`timescale 1ns/1ps
`default_nettype none
module odc_update_ctrl_bench
  import odc_pkg::*;
;
  localparam int unsigned WAKE = 5;
  logic clk, rst_n, clr_n, hw_n, ld_n, rsel, fmt, single, lreq, correction_engine_enable;
  logic go, hload, sel_n, host_ld_n, busy, ser_en, sdo_z, mon_oe;
  logic [1:0] gain6, sleep, ofs_en, ready;
  logic [2:0] chan;
  logic [3:0] mon_src;
  logic [7:0] drive, pdown;
  logic [15:0] data, in_data;
  logic [31:0] ofs;
  logic [127:0] out, exp;
  odc_write_t wr, eng;
  odc_monitor_t mon;
  int bad_count, cmp_count;

  odc_host_model odc_host_model_i (.i_clk(clk), .i_hw_reset_n(hw_n), .i_go(go),
    .i_chan(chan), .i_data(data), .i_load(hload), .o_select_n(sel_n),
    .o_write(wr), .o_latch_load_n(host_ld_n), .o_busy(busy));
  odc_update_ctrl #(.WAKE_CYCLES(WAKE)) odc_update_ctrl_i (.i_clk(clk), .i_rst_n(rst_n),
    .i_output_clear_n(clr_n), .i_hw_reset_n(hw_n), .i_latch_load_n(ld_n & host_ld_n),
    .i_reset_level_strap(rsel), .i_code_format_strap(fmt), .i_single_supply(single),
    .i_select_n(sel_n), .i_write(wr), .i_load_request_bit(lreq),
    .i_correction_engine_enable(correction_engine_enable), .i_engine_write(eng), .i_gain6(gain6),
    .i_group_sleep_bit(sleep), .i_monitor(mon), .o_serial_enable(ser_en),
    .o_sdo_hold_z(sdo_z), .o_channel_output(out), .o_channel_drive(drive),
    .o_channel_pulldown(pdown), .o_input_data(in_data), .o_offset_code(ofs),
    .o_offset_enable(ofs_en), .o_monitor_pin_oe(mon_oe), .o_monitor_source(mon_src),
    .o_group_ready(ready));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic chk(input logic [127:0] got, input logic [127:0] want);
    cmp_count++;
    if (got !== want) begin
      bad_count++;
      $display("Error at %0t: got %h expected %h", $time, got, want);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  // Power-on reset with the given straps and load level
  task automatic por(input logic r, input logic f, input logic s, input logic lvl);
    rst_n = 1'b0;
    rsel = r;
    fmt = f;
    single = s;
    ld_n = lvl;
    cyc(6);
    rst_n = 1'b1;
    cyc(6);
  endtask

  task automatic wrt(input logic [2:0] c, input logic [15:0] d, input logic l);
    chan = c;
    data = d;
    hload = l;
    go = 1'b1;
    cyc(1);
    go = 1'b0;
    repeat (40) if (busy) cyc(1);
    cyc(2);
  endtask

  task automatic t_por;
    for (int i = 0; i < 8; i++) begin
      por(i[0], i[1], i[2], 1'b1);
      chk(out, {8{(i[0] ^ i[1]) ? DATA_RST_MID : DATA_RST_ZERO}});
      chk(in_data, IN_DATA_RST);
      chk(ofs, i[2] ? 32'h0 : {2{i[1] ? OFS_G6_TWC : OFS_G6_BIN}});
      chk(ofs_en, i[2] ? 2'h0 : 2'h3);
    end
  endtask

  task automatic t_async;
    por(1'b0, 1'b0, 1'b0, 1'b0);
    exp = '0;
    exp[48 +: 16] = 16'hA5A5;
    wrt(3'h3, 16'hA5A5, 1'b1);
    chk(out, exp);
    correction_engine_enable = 1'b1;
    wrt(3'h2, 16'h1111, 1'b0);
    chk(out, exp);
    eng = {1'b1, 3'h2, 16'hBEEF};
    cyc(1);
    eng = '0;
    cyc(3);
    exp[32 +: 16] = 16'hBEEF;
    chk(out, exp);
    correction_engine_enable = 1'b0;
    clr_n = 1'b0;
    cyc(4);
    chk({drive, pdown}, 16'h00FF);
    clr_n = 1'b1;
    cyc(4);
    chk(drive, 8'hFF);
    chk(out, exp);
  endtask

  task automatic t_sync;
    por(1'b0, 1'b0, 1'b0, 1'b1);
    exp = '0;
    wrt(3'h5, 16'h1234, 1'b0);
    chk(out, exp);
    wrt(3'h6, 16'h0F0F, 1'b1);
    exp[80 +: 32] = 32'h0F0F_1234;
    chk(out, exp);
    wrt(3'h1, 16'h7777, 1'b0);
    lreq = 1'b1;
    cyc(3);
    lreq = 1'b0;
    cyc(1);
    exp[16 +: 16] = 16'h7777;
    chk(out, exp);
    gain6 = 2'b01;
    cyc(3);
    chk(ofs, {OFS_G4_BIN, OFS_G6_BIN});
    gain6 = 2'b11;
    clr_n = 1'b0;
    cyc(4);
    // Load pulse inside the clear window must be dropped
    wrt(3'h4, 16'h4444, 1'b1);
    chk(drive, 8'h00);
    chk(out, exp);
    clr_n = 1'b1;
    cyc(4);
    chk(drive, 8'h00);
    wrt(3'h0, 16'h0000, 1'b1);
    exp[64 +: 16] = 16'h4444;
    chk(drive, 8'hFF);
    chk(out, exp);
  endtask

  task automatic t_hw;
    hw_n = 1'b0;
    cyc(5);
    wrt(3'h7, 16'h9999, 1'b1);
    chk({ser_en, sdo_z}, 2'b01);
    chk(in_data, IN_DATA_RST);
    chk(out, 128'h0);
    hw_n = 1'b1;
    cyc(5);
    chk(ser_en, 1'b1);
    chk(out, 128'h0);
    wrt(3'h2, 16'h2222, 1'b1);
    chk(out[32 +: 16], 16'h2222);
  endtask

  task automatic t_misc;
    sleep = 2'b01;
    cyc(3);
    chk({drive[3:0], pdown[3:0], ready}, {4'h0, 4'hF, 2'b10});
    sleep = 2'b00;
    repeat (WAKE + 10) if (ready !== 2'b11) cyc(1);
    chk(ready, 2'b11);
    for (int s = 0; s < 14; s++) begin
      mon = {1'b1, s[3:0]};
      cyc(2);
      chk({mon_oe, mon_src}, {1'b1, s[3:0]});
    end
    mon = {1'b0, 4'h3};
    cyc(2);
    chk(mon_oe, 1'b0);
  endtask

  task automatic finish_test;
    $display("Counts: %0d mismatches, %0d compares", bad_count, cmp_count);
    if (bad_count == 0 && cmp_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge clk);
    bad_count++;
    $display("Error at %0t: watchdog expired", $time);
    finish_test();
  end

  initial begin
    {rst_n, rsel, fmt, single, lreq, correction_engine_enable, go, hload} = '0;
    {clr_n, hw_n, ld_n} = 3'b111;
    {chan, data, eng, mon, sleep} = '0;
    gain6 = 2'b11;
    bad_count = 0;
    cmp_count = 0;
    t_por();
    t_async();
    t_sync();
    t_hw();
    t_misc();
    finish_test();
  end
endmodule
`default_nettype wire
